//--- sfch_host.sv
`timescale 1ns/1ns
// Host controller for the serial flash: software writes opcode, address and data over APB,
// the controller shapes the frame and drives the pins in mode 0.
module sfch_host (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST_N,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Flash pins.
    output logic SCLK,
    output logic CS_N,
    output logic HOLD_N,
    output logic SIO0_O,
    output logic SIO0_OE,
    input wire logic SIO0_I,
    input wire logic SIO1_I
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SEL = 3'b001,
        S_SHIFT = 3'b011,
        S_BYTE = 3'b010,
        S_END = 3'b110,
        S_PAUSE = 3'b111
    } sfch_state_type;

    sfch_state_type state_ff;
    logic [7:0] cmd_ff;
    logic [23:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] rdata_ff;
    logic [7:0] div_ff;
    logic go_ff;
    logic pause_ff;
    logic last_ff;
    logic keep_ff;
    logic byte_rdy_ff;
    logic [2:0] phase_ff;
    logic [2:0] left_ff;
    logic [7:0] sh_ff;
    logic [7:0] in_ff;
    logic [2:0] bit_ff;
    logic sclk_ff;
    logic cs_n_ff;
    logic hold_n_ff;
    logic mosi_ff;
    logic mosi_oe_ff;
    logic rise_en;
    logic fall_en;
    logic run;
    logic [1:0] din;
    logic wr_acc;
    logic rd_acc;
    sfch_pkg::sfch_shape_type shape;

    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign rd_acc = PSEL && PENABLE && !PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign run = (state_ff == S_SHIFT);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Opcode table: decides what follows the opcode byte.
    always_comb begin
        shape = '0;
        unique case (cmd_ff)
            sfch_pkg::SET_WRITE_LATCH_CMD, sfch_pkg::CLEAR_WRITE_LATCH_CMD,
            sfch_pkg::WRITE_STATUS_CMD, sfch_pkg::READ_STATUS_CMD, sfch_pkg::READ_IDENT_CMD,
            sfch_pkg::WHOLE_WIPE_CMD, sfch_pkg::WHOLE_WIPE_ALT_CMD, sfch_pkg::DEEP_SLEEP_CMD: begin
                shape.known = 1'b1;
            end
            sfch_pkg::READ_CMD, sfch_pkg::SMALL_REGION_WIPE_CMD, sfch_pkg::MID_REGION_WIPE_CMD,
            sfch_pkg::MID_REGION_WIPE_ALT_CMD, sfch_pkg::PAGE_WRITE_CMD: begin
                shape.known = 1'b1;
                shape.addr_bytes = sfch_pkg::ADDR_BYTES;
            end
            sfch_pkg::FAST_READ_CMD, sfch_pkg::READ_PARAM_TABLE_CMD: begin
                shape.known = 1'b1;
                shape.addr_bytes = sfch_pkg::ADDR_BYTES;
                shape.dummy = 1'b1;
            end
            sfch_pkg::TWO_LINE_READ_CMD: begin
                shape.known = 1'b1;
                shape.addr_bytes = sfch_pkg::ADDR_BYTES;
                shape.dummy = 1'b1;
                shape.dual = 1'b1;
            end
            sfch_pkg::READ_SIG_CMD: begin
                shape.known = 1'b1;
                shape.addr_bytes = sfch_pkg::ADDR_BYTES;
            end
            sfch_pkg::READ_MAKER_DEV_CMD: begin
                shape.known = 1'b1;
                shape.addr_bytes = sfch_pkg::ADDR_BYTES;
            end
            default: shape = '0;
        endcase
    end

    sfch_sync #(.W(2)) u_sync (
        .clk(CLOCK),
        .rst_n(RST_N),
        .d({SIO1_I, SIO0_I}),
        .q(din)
    );

    sfch_clkdiv u_div (
        .clk(CLOCK),
        .rst_n(RST_N),
        .run(run),
        .half(div_ff),
        .rise_en(rise_en),
        .fall_en(fall_en)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Software registers.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_ff <= 8'h00;
            addr_ff <= 24'h000000;
            wdata_ff <= 8'h00;
            div_ff <= sfch_pkg::DIV_RESET;
            pause_ff <= 1'b0;
            last_ff <= 1'b0;
            keep_ff <= 1'b0;
        end else if (wr_acc) begin
            unique case (PADDR)
                sfch_pkg::REG_CTRL: begin
                    pause_ff <= PWDATA[sfch_pkg::CTRL_PAUSE];
                    last_ff <= PWDATA[sfch_pkg::CTRL_LAST];
                    keep_ff <= PWDATA[sfch_pkg::CTRL_KEEP];
                end
                sfch_pkg::REG_CMD: cmd_ff <= PWDATA[7:0];
                sfch_pkg::REG_ADDR: addr_ff <= PWDATA[23:0];
                sfch_pkg::REG_WDATA: wdata_ff <= PWDATA[7:0];
                sfch_pkg::REG_DIV: div_ff <= (PWDATA[7:0] == 8'h00) ? 8'h01 : PWDATA[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        PRDATA = 32'h00000000;
        if (rd_acc) begin
            unique case (PADDR)
                sfch_pkg::REG_CTRL: PRDATA = {28'h0000000, keep_ff, last_ff, pause_ff, go_ff};
                sfch_pkg::REG_CMD: PRDATA = {24'h000000, cmd_ff};
                sfch_pkg::REG_ADDR: PRDATA = {8'h00, addr_ff};
                sfch_pkg::REG_WDATA: PRDATA = {24'h000000, wdata_ff};
                sfch_pkg::REG_RDATA: PRDATA = {24'h000000, rdata_ff};
                sfch_pkg::REG_STAT: PRDATA = {28'h0000000, !cs_n_ff, state_ff == S_PAUSE,
                                              byte_rdy_ff, state_ff != S_IDLE};
                sfch_pkg::REG_DIV: PRDATA = {24'h000000, div_ff};
                default: PRDATA = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Frame engine. A go with select already low continues the frame by one data byte,
    // so streamed reads and page data go one byte per go. Unknown opcodes are refused here
    // rather than risked on the wire.
    logic go_req;
    assign go_req = wr_acc && (PADDR == sfch_pkg::REG_CTRL) && PWDATA[sfch_pkg::CTRL_GO];

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= S_IDLE;
            go_ff <= 1'b0;
            byte_rdy_ff <= 1'b0;
            phase_ff <= 3'h0;
            left_ff <= 3'h0;
            sh_ff <= 8'h00;
            in_ff <= 8'h00;
            rdata_ff <= 8'h00;
            bit_ff <= 3'h0;
            sclk_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            hold_n_ff <= 1'b1;
            mosi_ff <= 1'b0;
            mosi_oe_ff <= 1'b0;
        end else begin
            if (rd_acc && PADDR == sfch_pkg::REG_RDATA)
                byte_rdy_ff <= 1'b0;
            unique case (state_ff)
                S_IDLE: begin
                    hold_n_ff <= 1'b1;
                    if (go_req && cs_n_ff && shape.known) begin
                        go_ff <= 1'b1;
                        cs_n_ff <= 1'b0;
                        sh_ff <= cmd_ff;
                        left_ff <= shape.addr_bytes;
                        phase_ff <= 3'h0;
                        state_ff <= S_SEL;
                    end else if (go_req && !cs_n_ff) begin
                        go_ff <= 1'b1;
                        sh_ff <= wdata_ff;
                        phase_ff <= 3'h4;
                        state_ff <= S_SEL;
                    end
                end
                S_SEL: begin
                    // Both lines carry read data in a two-line data byte, so the host lets go of its line.
                    mosi_oe_ff <= !(shape.dual && phase_ff == 3'h4);
                    mosi_ff <= sh_ff[7];
                    bit_ff <= 3'h7;
                    state_ff <= S_SHIFT;
                end
                S_SHIFT: begin
                    if (rise_en) begin
                        sclk_ff <= 1'b1;
                        in_ff <= shape.dual && phase_ff == 3'h4 ? {in_ff[5:0], din[1], din[0]}
                                                               : {in_ff[6:0], din[1]};
                    end
                    if (fall_en) begin
                        sclk_ff <= 1'b0;
                        if (bit_ff == 3'h0 || (shape.dual && phase_ff == 3'h4 && bit_ff == 3'h4)) begin
                            state_ff <= S_BYTE;
                        end else begin
                            bit_ff <= bit_ff - 3'h1;
                            sh_ff <= {sh_ff[6:0], 1'b0};
                            mosi_ff <= sh_ff[6];
                        end
                    end
                end
                S_BYTE: begin
                    if (phase_ff == 3'h0 && left_ff != 3'h0) begin
                        phase_ff <= 3'h1;
                        left_ff <= left_ff - 3'h1;
                        sh_ff <= addr_ff[23:16];
                        state_ff <= S_SEL;
                    end else if (phase_ff == 3'h1 && left_ff != 3'h0) begin
                        left_ff <= left_ff - 3'h1;
                        sh_ff <= left_ff == 3'h2 ? addr_ff[15:8] : addr_ff[7:0];
                        state_ff <= S_SEL;
                    end else if (phase_ff != 3'h4 && phase_ff != 3'h2 && shape.dummy) begin
                        phase_ff <= 3'h2;
                        sh_ff <= 8'h00;
                        state_ff <= S_SEL;
                    end else begin
                        if (phase_ff == 3'h4) begin
                            rdata_ff <= in_ff;
                            byte_rdy_ff <= 1'b1;
                        end
                        mosi_oe_ff <= !shape.dual;
                        state_ff <= S_END;
                    end
                end
                S_END: begin
                    go_ff <= 1'b0;
                    if (last_ff || !keep_ff) begin
                        cs_n_ff <= 1'b1;
                        mosi_oe_ff <= 1'b0;
                    end
                    state_ff <= S_IDLE;
                end
                S_PAUSE: begin
                    hold_n_ff <= 1'b0;
                    if (!pause_ff) begin
                        hold_n_ff <= 1'b1;
                        state_ff <= S_SHIFT;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
            // A pause lets a rising edge due in the same cycle pass first, so the clock stays low while paused.
            if (pause_ff && state_ff == S_SHIFT && !sclk_ff && !rise_en && !cs_n_ff)
                state_ff <= S_PAUSE;
        end
    end

    assign SCLK = sclk_ff;
    assign CS_N = cs_n_ff;
    assign HOLD_N = hold_n_ff;
    assign SIO0_O = mosi_ff;
    assign SIO0_OE = mosi_oe_ff;
endmodule : sfch_host

//--- sfch_pkg.sv
package sfch_pkg;
    // Software register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_WDATA = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam logic [7:0] REG_DIV = 8'h18;
    // Control register fields.
    localparam int CTRL_GO = 0;
    localparam int CTRL_PAUSE = 1;
    localparam int CTRL_LAST = 2;
    localparam int CTRL_KEEP = 3;
    // Status register fields.
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_PAUSED = 2;
    localparam int STAT_SEL = 3;
    localparam logic [7:0] DIV_RESET = 8'h04;
    // Flash status byte layout.
    localparam int FL_BUSY_FLAG = 0;
    localparam int FL_WRITE_LATCH_BIT = 1;
    // Opcodes.
    localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
    localparam logic [7:0] READ_IDENT_CMD = 8'h9F;
    localparam logic [7:0] READ_STATUS_CMD = 8'h05;
    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [7:0] FAST_READ_CMD = 8'h0B;
    localparam logic [7:0] READ_PARAM_TABLE_CMD = 8'h5A;
    localparam logic [7:0] READ_SIG_CMD = 8'hAB;
    localparam logic [7:0] READ_MAKER_DEV_CMD = 8'h90;
    localparam logic [7:0] TWO_LINE_READ_CMD = 8'h3B;
    localparam logic [7:0] SMALL_REGION_WIPE_CMD = 8'h20;
    localparam logic [7:0] MID_REGION_WIPE_CMD = 8'h52;
    localparam logic [7:0] MID_REGION_WIPE_ALT_CMD = 8'hD8;
    localparam logic [7:0] WHOLE_WIPE_CMD = 8'h60;
    localparam logic [7:0] WHOLE_WIPE_ALT_CMD = 8'hC7;
    localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
    localparam logic [7:0] DEEP_SLEEP_CMD = 8'hB9;
    localparam logic [7:0] WAKE_CMD = 8'hAB;
    localparam logic [2:0] ADDR_BYTES = 3'h3;
    localparam logic [2:0] MAKER_DEV_FILL = 3'h2;

    // Shape of a command: how many address and dummy bytes follow the opcode.
    typedef struct packed {
        logic known;
        logic [2:0] addr_bytes;
        logic dummy;
        logic dual;
    } sfch_shape_type;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic hold_n;
        logic mosi_o;
        logic mosi_oe;
    } sfch_pins_type;
endpackage : sfch_pkg

//--- sfch_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser; only the second stage is visible.
module sfch_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : sfch_sync

//--- sfch_clkdiv.sv
`timescale 1ns/1ns
// Divider giving one-cycle enables at the two half-period points of the serial clock.
module sfch_clkdiv (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [7:0] half,
    output logic rise_en,
    output logic fall_en
);
    logic [7:0] cnt_ff;
    logic phase_ff;
    logic tick;

    assign tick = run && (cnt_ff >= half - 8'h01);
    assign rise_en = tick && !phase_ff;
    assign fall_en = tick && phase_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'h00;
            phase_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff <= 8'h00;
            phase_ff <= 1'b0;
        end else if (tick) begin
            cnt_ff <= 8'h00;
            phase_ff <= !phase_ff;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule : sfch_clkdiv

//--- sfch_host_props.sv
`timescale 1ns/1ns
module sfch_host_props (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST_N,
    // Flash pins.
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic HOLD_N,
    input wire logic SIO0_O,
    input wire logic SIO0_OE
);
    logic sclk_q_ff;
    logic [7:0] op_ff;
    int bits_ff;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////
    // Dual reads end on half bytes, so the opcode is kept to exempt them.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sclk_q_ff <= 1'b0;
            op_ff <= 8'h00;
            bits_ff <= 0;
        end else begin
            sclk_q_ff <= SCLK;
            if (CS_N) begin
                bits_ff <= 0;
            end else if (SCLK && !sclk_q_ff) begin
                bits_ff <= bits_ff + 1;
                op_ff <= (bits_ff < 8) ? {op_ff[6:0], SIO0_O} : op_ff;
            end
        end
    end
    ////////////////////////////////////////
    sequence s_hold_drop;
        $fell(HOLD_N);
    endsequence
    sequence s_hold_lift;
        $rose(HOLD_N);
    endsequence
    a_pause_start: assert property (s_hold_drop |-> !CS_N && !SCLK) else $error("pause start bad");
    a_pause_end: assert property (s_hold_lift |-> !SCLK) else $error("pause end bad");
    a_pause_quiet: assert property (!HOLD_N |-> !SCLK && $stable(SIO0_O)) else $error("moved in pause");
    a_pause_sel_held: assert property (!HOLD_N |-> !CS_N) else $error("deselect in pause");
    a_select_resume: assert property ($fell(CS_N) |-> HOLD_N ##1 !SCLK) else $error("select bad");
    a_byte_boundary: assert property ($rose(CS_N) && op_ff != 8'h3B |-> bits_ff % 8 == 0) else $error("byte cut");
    a_data_steady: assert property (SCLK && !CS_N |-> $stable(SIO0_O)) else $error("data moved");
    a_sclk_idle: assert property (CS_N |-> !SCLK) else $error("clock while idle");
    a_drive_sel: assert property (SIO0_OE |-> !CS_N) else $error("drive while idle");
endmodule : sfch_host_props
bind sfch_host sfch_host_props i_sfch_host_props (.CLOCK(CLOCK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N),
    .HOLD_N(HOLD_N), .SIO0_O(SIO0_O), .SIO0_OE(SIO0_OE));

//--- sfch_flash_model.sv
`timescale 1ns/1ns
module sfch_flash_model #(
    // Identity values are arbitrary.
    parameter logic [7:0] MAKER_ID = 8'h3C,
    parameter logic [15:0] DEV_ID = 16'h1E2D,
    parameter logic [7:0] SIG_ID = 8'h4B,
    parameter int BUSY_NS = 5000
) (
    // Serial bus from the host.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic si,
    // Serial data back to the host.
    output logic so0,
    output logic so1
);
    logic latch = 1'b0;
    logic paused = 1'b0;
    logic drive = 1'b0;
    logic dual = 1'b0;
    logic q0 = 1'b0;
    logic q1 = 1'b0;
    logic [7:0] op = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [23:0] addr = 24'h0;
    int bits = 0;
    int hdr;
    time busy_end = 0;
    ////////////////////////////////////////
    // Released lines show the inverse of the last bit, so a stale copy never passes.
    assign so1 = (drive && !paused && !cs_n) ? q1 : ~q1;
    assign so0 = (drive && dual && !paused && !cs_n) ? q0 : ~q0;
    function automatic int hdr_bits(input logic [7:0] o);
        case (o)
            8'h05, 8'h9F: hdr_bits = 8;
            8'h03, 8'h90, 8'hAB: hdr_bits = 32;
            8'h0B, 8'h3B, 8'h5A: hdr_bits = 40;
            default: hdr_bits = 0;
        endcase
    endfunction : hdr_bits
    function automatic logic [7:0] out_byte(input int n);
        case (op)
            8'h05: out_byte = {6'h00, latch, $time < busy_end};
            8'h9F: out_byte = (n % 3 == 0) ? MAKER_ID : (n % 3 == 1) ? DEV_ID[15:8] : DEV_ID[7:0];
            8'h90: out_byte = ((n + addr[0]) % 2 == 0) ? MAKER_ID : DEV_ID[7:0];
            8'hAB: out_byte = SIG_ID;
            default: out_byte = (addr[7:0] + 8'(n)) ^ 8'hA5;
        endcase
    endfunction : out_byte
    always @(hold_n or sclk or cs_n) begin
        if (cs_n) begin
            paused = 1'b0;
        end else if (!sclk) begin
            paused = !hold_n;
        end
    end
    always @(negedge cs_n) begin
        bits = 0;
        drive = 1'b0;
    end
    always @(posedge cs_n) begin
        drive = 1'b0;
        if (bits > 0 && bits % 8 == 0) begin
            if (op == 8'h06) begin
                latch = 1'b1;
            end else if (op == 8'h04) begin
                latch = 1'b0;
            end else if (latch && op inside {8'h01, 8'h02, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7}) begin
                busy_end = $time + BUSY_NS;
                fork
                    #(BUSY_NS) latch = 1'b0;
                join_none
            end
        end
    end
    always @(posedge sclk) begin
        if (!cs_n && !paused) begin
            if (bits < 8) begin
                op = {op[6:0], si};
            end else if (bits < 32) begin
                addr = {addr[22:0], si};
            end
            bits = bits + 1;
            hdr = hdr_bits(op);
            dual = (op == 8'h3B);
            if (hdr > 0 && bits >= hdr && (bits - hdr) % (dual ? 4 : 8) == 0) begin
                sh = out_byte((bits - hdr) / (dual ? 4 : 8));
                drive = 1'b1;
            end
        end
    end
    always @(negedge sclk) begin
        if (!cs_n && !paused && drive) begin
            q1 = sh[7];
            q0 = sh[6];
            sh = dual ? sh << 2 : sh << 1;
        end
    end
endmodule : sfch_flash_model

//--- sfch_host_tb_top.sv
`timescale 1ns/1ns
module sfch_host_tb_top;
    localparam logic [31:0] GO = 32'h1 << sfch_pkg::CTRL_GO;
    localparam logic [31:0] KEEP = 32'h1 << sfch_pkg::CTRL_KEEP;
    localparam logic [31:0] LAST = 32'h1 << sfch_pkg::CTRL_LAST;
    localparam logic [31:0] PAUSE = 32'h1 << sfch_pkg::CTRL_PAUSE;
    // Identity values are arbitrary.
    localparam logic [7:0] MAKER = 8'h3C;
    localparam logic [15:0] DEV = 16'h1E2D;
    localparam logic [7:0] SIG = 8'h4B;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, sclk, cs_n, hold_n, sio0_o, sio0_oe, so0, so1;
    int err_count = 0;
    int samples_checked = 0;
    // The shared data line follows whichever end drives it.
    wire logic sio0_i = sio0_oe ? sio0_o : so0;
    always #5 clock = ~clock;
    sfch_host i_sfch_host (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCLK(sclk),
        .CS_N(cs_n), .HOLD_N(hold_n), .SIO0_O(sio0_o), .SIO0_OE(sio0_oe), .SIO0_I(sio0_i), .SIO1_I(so1));
    sfch_flash_model #(.MAKER_ID(MAKER), .DEV_ID(DEV), .SIG_ID(SIG)) i_sfch_flash_model (.sclk(sclk),
        .cs_n(cs_n), .hold_n(hold_n), .si(sio0_o), .so0(so0), .so1(so1));
    ////////////////////////////////////////
    task automatic finish_test();
        $display("err_count=%0d samples_checked=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic stuck();
        err_count++;
        $display("unexpected at %0t: wait ran out", $time);
        finish_test();
    endtask : stuck
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) stuck();
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    // Completion is judged from the busy flag, never from a guessed cycle count.
    task automatic go(input logic [31:0] c);
        int n;
        apb(1'b1, sfch_pkg::REG_CTRL, c);
        n = 0;
        do begin
            apb(1'b0, sfch_pkg::REG_STAT, 32'h0);
            n++;
        end while (q[sfch_pkg::STAT_BUSY] !== 1'b0 && n < 500);
        if (n >= 500) stuck();
    endtask : go
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [31:0] c);
        apb(1'b1, sfch_pkg::REG_CMD, {24'h0, op});
        apb(1'b1, sfch_pkg::REG_ADDR, {8'h0, a});
        go(c);
    endtask : cmd
    task automatic rbyte(input logic [31:0] c, input logic [7:0] exp);
        go(c);
        apb(1'b0, sfch_pkg::REG_RDATA, 32'h0);
        chk(q & 32'hFF, {24'h0, exp});
    endtask : rbyte
    task automatic stat(input logic [7:0] exp);
        cmd(8'h05, 24'h0, GO | KEEP);
        rbyte(GO | LAST, exp);
    endtask : stat
    ////////////////////////////////////////
    task automatic t_reset();
        chk({cs_n, hold_n, sclk, sio0_oe}, 32'hC);
        apb(1'b0, sfch_pkg::REG_DIV, 32'h0);
        chk(q, {24'h0, sfch_pkg::DIV_RESET});
        apb(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0);
        chk(pslverr, 32'h0);
        cmd(8'hFF, 24'h0, GO | KEEP);
        chk(cs_n, 32'h1);
    endtask : t_reset
    task automatic t_latch();
        cmd(8'h06, 24'h0, GO);
        cmd(8'h05, 24'h0, GO | KEEP);
        rbyte(GO | KEEP, 8'h02);
        rbyte(GO | LAST, 8'h02);
        cmd(8'h04, 24'h0, GO);
        stat(8'h00);
    endtask : t_latch
    task automatic t_ident();
        cmd(8'h9F, 24'h0, GO | KEEP);
        rbyte(GO | KEEP, MAKER);
        rbyte(GO | KEEP, DEV[15:8]);
        rbyte(GO | LAST, DEV[7:0]);
    endtask : t_ident
    task automatic t_reads();
        logic [7:0] ops [4] = '{8'h03, 8'h0B, 8'h3B, 8'h5A};
        foreach (ops[i]) begin
            cmd(ops[i], 24'h123456, GO | KEEP);
            rbyte(GO | KEEP, 8'h56 ^ 8'hA5);
            rbyte(GO | LAST, 8'h57 ^ 8'hA5);
        end
    endtask : t_reads
    task automatic t_ids();
        for (int s = 0; s < 2; s++) begin
            cmd(8'h90, 24'(s), GO | KEEP);
            rbyte(GO | KEEP, s ? DEV[7:0] : MAKER);
            rbyte(GO | LAST, s ? MAKER : DEV[7:0]);
        end
        cmd(8'hB9, 24'h0, GO);
        cmd(8'hAB, 24'h0, GO | KEEP);
        rbyte(GO | LAST, SIG);
    endtask : t_ids
    task automatic t_modify();
        logic [7:0] ops [7] = '{8'h01, 8'h02, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
        int n;
        cmd(8'h20, 24'h001000, GO);
        stat(8'h00);
        foreach (ops[i]) begin
            cmd(8'h06, 24'h0, GO);
            cmd(ops[i], 24'h001000, GO);
            stat(8'h03);
            n = 0;
            do begin
                cmd(8'h05, 24'h0, GO | KEEP);
                go(GO | LAST);
                apb(1'b0, sfch_pkg::REG_RDATA, 32'h0);
                n++;
            end while (q[0] !== 1'b0 && n < 20);
            chk(q & 32'hFF, 32'h0);
        end
    endtask : t_modify
    task automatic t_pause();
        int n;
        apb(1'b1, sfch_pkg::REG_CMD, 32'h9F);
        apb(1'b1, sfch_pkg::REG_CTRL, GO | KEEP);
        repeat (20) @(posedge clock);
        apb(1'b1, sfch_pkg::REG_CTRL, KEEP | PAUSE);
        n = 0;
        while (hold_n !== 1'b0 && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (n >= 100) stuck();
        repeat (60) begin
            @(posedge clock);
            chk(sclk, 32'h0);
        end
        apb(1'b0, sfch_pkg::REG_STAT, 32'h0);
        chk(q[sfch_pkg::STAT_PAUSED], 32'h1);
        go(KEEP);
        rbyte(GO | KEEP, MAKER);
        rbyte(GO | LAST, DEV[15:8]);
    endtask : t_pause
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_latch();
        t_ident();
        t_reads();
        t_ids();
        t_modify();
        t_pause();
        finish_test();
    end
endmodule : sfch_host_tb_top
